// ===== verilog/dca_regs.svh
`ifndef DCA_REGS_SVH
`define DCA_REGS_SVH
`define DCA_NUM_W 16
`define DCA_W_DEFAULT 4'h0
`define DCA_W_MUL_LO 4'h4
`define DCA_W_X_BASE 4'h8
`define DCA_W_X_IDX 4'h9
`define DCA_W_Y_BASE 4'hA
`define DCA_W_Y_IDX 4'hB
`define DCA_W_INDEX 4'hC
`define DCA_ONES 16'hFFFF
`define DCA_ACC_MAX 40'h7FFFFFFFFF
`define DCA_ACC_MIN 40'h8000000000
`define DCA_OFS_CTRL 12'h000
`define DCA_OFS_STAT 12'h004
`define DCA_OFS_RES 12'h008
`define DCA_OFS_WBASE 12'h040
`define DCA_OFS_ACCA 12'h080
`define DCA_OFS_ACCB 12'h084
`define DCA_OFS_XADR 12'h088
`define DCA_OFS_YADR 12'h08C
`define DCA_OFS_PROG 12'h090
`define DCA_FLAG_C 0
`define DCA_FLAG_Z 1
`define DCA_FLAG_OV 2
`define DCA_FLAG_N 3
`define DCA_FLAG_DC 4
`define DCA_FLAG_OA 5
`define DCA_FLAG_OB 6
`define DCA_FLAG_SA 7
`define DCA_FLAG_SB 8
`define DCA_PROG_CYCLES 2'h2
`endif

// ===== verilog/dca_pkg.sv
package dca_pkg;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_ROTATE_RIGHT_NOCARRY = 4'h1,
    OP_SIGN_EXTEND = 4'h2,
    OP_ZERO_FILL = 4'h3,
    OP_SET_ONES = 4'h4,
    OP_SHIFT_LEFT = 4'h5,
    OP_ACCUM_ARITH_SHIFT = 4'h6,
    OP_SUB_WITH_BORROW = 4'h7,
    OP_REVERSE_SUB_WITH_BORROW = 4'h8,
    OP_PROG_HIGH_READ = 4'h9,
    OP_PROG_LOW_READ = 4'hA,
    OP_PROG_HIGH_WRITE = 4'hB,
    OP_PROG_LOW_WRITE = 4'hC,
    OP_PREFETCH = 4'hD,
    OP_SQUARE = 4'hE,
    OP_DSP_MUL = 4'hF
  } dca_op_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PROG = 3'b010,
    ST_DONE = 3'b100
  } dca_state_e;
  typedef struct packed {
    dca_op_e op;
    logic [3:0] src;
    logic [3:0] base;
    logic [3:0] dst;
    logic use_lit;
    logic [5:0] lit;
    logic acc_sel;
    logic src_byte;
    logic [2:0] xmode;
    logic [2:0] ymode;
  } dca_cmd_s;
  typedef struct packed {
    logic [15:0] res;
    logic [8:0] flags;
    logic [8:0] fmask;
  } dca_alu_s;
endpackage

// ===== verilog/dca_alu.sv
`timescale 1ns/1ps
`include "dca_regs.svh"
module dca_alu (
  // Command and operands
  input wire dca_pkg::dca_cmd_s cmd,
  input wire logic [15:0] opa,
  input wire logic [15:0] opb,
  input wire logic carry_in,
  // Result
  output dca_pkg::dca_alu_s out
);
  function automatic logic [16:0] sub_b(input logic [15:0] a, input logic [15:0] b, input logic cin);
    sub_b = {1'b0, a} + {1'b0, ~b} + {16'h0000, cin};
  endfunction
  logic [16:0] diff;
  logic [4:0] half;
  logic [15:0] lhs;
  logic [15:0] rhs;
  always_comb begin
    out = '0;
    lhs = opa;
    rhs = opb;
    if (cmd.op == dca_pkg::OP_REVERSE_SUB_WITH_BORROW) begin
      lhs = opb;
      rhs = opa;
    end
    diff = sub_b(lhs, rhs, carry_in);
    half = {1'b0, lhs[3:0]} + {1'b0, ~rhs[3:0]} + {4'h0, carry_in};
    case (cmd.op)
      dca_pkg::OP_ROTATE_RIGHT_NOCARRY: begin
        out.res = {opb[0], opb[15:1]};
        out.fmask[`DCA_FLAG_N] = 1'b1;
        out.fmask[`DCA_FLAG_Z] = 1'b1;
      end
      dca_pkg::OP_SIGN_EXTEND, dca_pkg::OP_ZERO_FILL: begin
        if (cmd.op == dca_pkg::OP_SIGN_EXTEND) begin
          out.res = {{8{opb[7]}}, opb[7:0]};
          out.flags[`DCA_FLAG_C] = ~opb[7];
        end else begin
          out.res = {8'h00, opb[7:0]};
          out.flags[`DCA_FLAG_C] = 1'b1;
        end
        out.fmask[`DCA_FLAG_C] = 1'b1;
        out.fmask[`DCA_FLAG_N] = 1'b1;
        out.fmask[`DCA_FLAG_Z] = 1'b1;
      end
      dca_pkg::OP_SET_ONES: out.res = `DCA_ONES;
      dca_pkg::OP_SHIFT_LEFT: begin
        out.res = (opb[4:0] > 5'h0F) ? 16'h0000 : opa << opb[3:0];
        out.fmask[`DCA_FLAG_N] = 1'b1;
        out.fmask[`DCA_FLAG_Z] = 1'b1;
      end
      dca_pkg::OP_SUB_WITH_BORROW, dca_pkg::OP_REVERSE_SUB_WITH_BORROW: begin
        out.res = diff[15:0];
        out.flags[`DCA_FLAG_C] = diff[16];
        out.flags[`DCA_FLAG_DC] = half[4];
        out.flags[`DCA_FLAG_OV] = (lhs[15] != rhs[15]) && (diff[15] != lhs[15]);
        out.fmask[`DCA_FLAG_C] = 1'b1;
        out.fmask[`DCA_FLAG_DC] = 1'b1;
        out.fmask[`DCA_FLAG_OV] = 1'b1;
        out.fmask[`DCA_FLAG_N] = 1'b1;
        out.fmask[`DCA_FLAG_Z] = 1'b1;
      end
      default: out.res = 16'h0000;
    endcase
    out.flags[`DCA_FLAG_N] = out.res[15];
    out.flags[`DCA_FLAG_Z] = (out.res == 16'h0000);
  end
endmodule

// ===== verilog/dca_core.sv
`timescale 1ns/1ps
`include "dca_regs.svh"
// Contract
// - Sixteen working registers, each usable as source, destination or base.
// - File-register form uses working register zero for the result; the operand still comes from the source register.
// - Square multiplies one of registers 4 to 7 by itself.
// - DSP multiply accepts only the six distinct pairs from registers 4 to 7.
// - Divide takes dividend and divisor from a direct register pair.
// - X prefetch from register 8 or 9, post-modified by 2/4/6, or 9 plus 12.
// - Y prefetch from register 10 or 11, post-modified by 2/4/6, or 11 plus 12.
// - Prefetched X and Y data go to a register among 4 to 7.
// - Rotate right without carry, one cycle, updates only N and Z.
// - Sign extend to a direct destination, updating C, N and Z.
// - Zero extend to a direct destination, updating C, Z and N.
// - Left shift by register or five-bit literal, updating only N and Z.
// - Accumulator arithmetic shift by register or signed six-bit literal, sets OA/OB/SA/SB.
// - Subtract with borrow is a minus b minus inverted carry, five flags.
// - High program read puts bits 23..16 in destination 7..0, two cycles.
// - Low program read puts bits 15..0 in destination, two cycles.
// - High program write stores source 7..0 to bits 23..16, two cycles.
// - Low program write stores full source to bits 15..0, two cycles.
module dca_core #(
  parameter int PROG_DEPTH = 64,
  parameter int PROG_AW = 6
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Status
  output logic busy
);
  // ********************************
  // Architectural state
  // ********************************
  logic [15:0] w_ff [0:`DCA_NUM_W-1];
  logic [15:0] nxt_w [0:`DCA_NUM_W-1];
  logic [8:0] flags_ff;
  logic [8:0] nxt_flags;
  logic [39:0] acc_ff [0:1];
  logic [39:0] nxt_acc [0:1];
  logic [23:0] prog_mem [0:PROG_DEPTH-1];
  logic [15:0] xdata_ff;
  logic [15:0] ydata_ff;
  logic [15:0] nxt_xdata;
  logic [15:0] nxt_ydata;
  logic [15:0] xadr_ff;
  logic [15:0] yadr_ff;
  logic [15:0] nxt_xadr;
  logic [15:0] nxt_yadr;
  logic [31:0] prod_ff;
  logic [31:0] nxt_prod;
  logic err_ff;
  logic nxt_err;
  dca_pkg::dca_cmd_s cmd_ff;
  dca_pkg::dca_cmd_s nxt_cmd;
  dca_pkg::dca_state_e state_ff;
  dca_pkg::dca_state_e nxt_state;
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic [31:0] nxt_prdata;
  logic nxt_pready;
  logic nxt_pslverr;
  logic [15:0] res_ff;
  logic [15:0] nxt_res;

  function automatic logic [15:0] post_mod(input logic [15:0] a, input logic [2:0] m);
    case (m)
      3'h1: post_mod = a + 16'h0002;
      3'h2: post_mod = a + 16'h0004;
      3'h3: post_mod = a + 16'h0006;
      3'h5: post_mod = a - 16'h0002;
      3'h6: post_mod = a - 16'h0004;
      3'h7: post_mod = a - 16'h0006;
      default: post_mod = a;
    endcase
  endfunction

  function automatic logic [PROG_AW-1:0] paddr_of(input logic [15:0] a);
    paddr_of = a[PROG_AW:1];
  endfunction

  // ********************************
  // Operand selection
  // ********************************
  logic apb_wr;
  logic apb_rd;
  logic [15:0] opa;
  logic [15:0] opb;
  dca_pkg::dca_alu_s alu;
  logic [3:0] wsel;
  logic [3:0] base_sel;
  logic [3:0] dst_sel;
  logic [15:0] pf_x;
  logic [15:0] pf_y;
  logic [39:0] sh_acc;
  logic signed [6:0] amt;
  logic [23:0] pword;
  logic pair_ok;
  logic [3:0] mdst;
  assign apb_wr = psel && penable && pwrite && !pready;
  assign apb_rd = psel && penable && !pwrite && !pready;
  assign base_sel = cmd_ff.base;
  assign wsel = cmd_ff.src;
  assign dst_sel = cmd_ff.dst;
  assign opa = w_ff[base_sel];
  assign opb = cmd_ff.use_lit ? {10'h000, cmd_ff.lit} : w_ff[wsel];
  assign pword = prog_mem[paddr_of(w_ff[wsel])];
  // Pair legal only when both in 4..7 and base below source
  assign pair_ok = (base_sel[3:2] == 2'b01) && (wsel[3:2] == 2'b01) && (base_sel < wsel);
  assign mdst = {2'b01, cmd_ff.dst[1:0]};

  dca_alu dca_alu_inst (
    .cmd(cmd_ff),
    .opa(opa),
    .opb(opb),
    .carry_in(flags_ff[`DCA_FLAG_C]),
    .out(alu)
  );

  always_comb begin
    pf_x = (cmd_ff.xmode == 3'h4) ? w_ff[`DCA_W_X_IDX] + w_ff[`DCA_W_INDEX]
         : w_ff[cmd_ff.src_byte ? `DCA_W_X_IDX : `DCA_W_X_BASE];
    pf_y = (cmd_ff.ymode == 3'h4) ? w_ff[`DCA_W_Y_IDX] + w_ff[`DCA_W_INDEX]
         : w_ff[cmd_ff.src_byte ? `DCA_W_Y_IDX : `DCA_W_Y_BASE];
    amt = cmd_ff.use_lit ? {cmd_ff.lit[5], cmd_ff.lit} : {w_ff[wsel][5], w_ff[wsel][5:0]};
    if (amt >= 0) begin
      sh_acc = $signed(acc_ff[cmd_ff.acc_sel]) >>> amt[5:0];
    end else begin
      sh_acc = acc_ff[cmd_ff.acc_sel] << 6'(-amt);
    end
  end

  // ********************************
  // Sequencer and datapath next state
  // ********************************
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_cmd = cmd_ff;
    nxt_flags = flags_ff;
    for (int i = 0; i < `DCA_NUM_W; i++) begin
      nxt_w[i] = w_ff[i];
    end
    nxt_acc[0] = acc_ff[0];
    nxt_acc[1] = acc_ff[1];
    nxt_xdata = xdata_ff;
    nxt_ydata = ydata_ff;
    nxt_xadr = xadr_ff;
    nxt_yadr = yadr_ff;
    nxt_prod = prod_ff;
    nxt_err = err_ff;
    nxt_res = res_ff;
    case (state_ff)
      dca_pkg::ST_IDLE: begin
        if (apb_wr && paddr == `DCA_OFS_CTRL) begin
          nxt_cmd = dca_pkg::dca_cmd_s'(pwdata[$bits(dca_pkg::dca_cmd_s)-1:0]);
          nxt_state = dca_pkg::ST_DONE;
          if (nxt_cmd.op inside {dca_pkg::OP_PROG_HIGH_READ, dca_pkg::OP_PROG_LOW_READ,
                                 dca_pkg::OP_PROG_HIGH_WRITE, dca_pkg::OP_PROG_LOW_WRITE}) begin
            nxt_state = dca_pkg::ST_PROG;
            nxt_cnt = `DCA_PROG_CYCLES - 2'h1;
          end
        end
      end
      dca_pkg::ST_PROG: begin
        nxt_cnt = cnt_ff - 2'h1;
        if (cnt_ff == 2'h1) begin
          nxt_state = dca_pkg::ST_DONE;
        end
      end
      dca_pkg::ST_DONE: begin
        nxt_state = dca_pkg::ST_IDLE;
        // Flags merge through the mask so untouched bits keep their value
        nxt_flags = (flags_ff & ~alu.fmask) | (alu.flags & alu.fmask);
        case (cmd_ff.op)
          dca_pkg::OP_ROTATE_RIGHT_NOCARRY, dca_pkg::OP_SET_ONES, dca_pkg::OP_SUB_WITH_BORROW,
          dca_pkg::OP_REVERSE_SUB_WITH_BORROW, dca_pkg::OP_SIGN_EXTEND, dca_pkg::OP_ZERO_FILL,
          dca_pkg::OP_SHIFT_LEFT: begin
            nxt_res = alu.res;
            // File-register form writes the default working register
            nxt_w[cmd_ff.src_byte ? `DCA_W_DEFAULT : dst_sel] = alu.res;
          end
          dca_pkg::OP_ACCUM_ARITH_SHIFT: begin
            nxt_acc[cmd_ff.acc_sel] = sh_acc;
            nxt_flags[cmd_ff.acc_sel ? `DCA_FLAG_OB : `DCA_FLAG_OA] =
              ((amt >= 0) ? 1'b0 : ($signed(sh_acc) >>> 6'(-amt)) != $signed(acc_ff[cmd_ff.acc_sel]));
            nxt_flags[cmd_ff.acc_sel ? `DCA_FLAG_SB : `DCA_FLAG_SA] =
              (sh_acc == `DCA_ACC_MAX) || (sh_acc == `DCA_ACC_MIN);
          end
          dca_pkg::OP_PROG_HIGH_READ: begin
            nxt_w[dst_sel] = {8'h00, pword[23:16]};
            nxt_res = {8'h00, pword[23:16]};
          end
          dca_pkg::OP_PROG_LOW_READ: begin
            nxt_w[dst_sel] = pword[15:0];
            nxt_res = pword[15:0];
          end
          dca_pkg::OP_PREFETCH: begin
            if (cmd_ff.xmode != 3'h0 || cmd_ff.src_byte) begin
              nxt_xadr = pf_x;
              nxt_w[mdst] = xdata_ff;
              if (cmd_ff.xmode != 3'h4) begin
                nxt_w[cmd_ff.src_byte ? `DCA_W_X_IDX : `DCA_W_X_BASE] = post_mod(pf_x, cmd_ff.xmode);
              end
            end
            if (cmd_ff.ymode != 3'h0) begin
              nxt_yadr = pf_y;
              nxt_w[{2'b01, cmd_ff.base[1:0]}] = ydata_ff;
              if (cmd_ff.ymode != 3'h4) begin
                nxt_w[cmd_ff.src_byte ? `DCA_W_Y_IDX : `DCA_W_Y_BASE] = post_mod(pf_y, cmd_ff.ymode);
              end
            end
          end
          dca_pkg::OP_SQUARE: begin
            nxt_err = (dst_sel[3:2] != 2'b01);
            nxt_prod = $signed(w_ff[mdst]) * $signed(w_ff[mdst]);
          end
          dca_pkg::OP_DSP_MUL: begin
            nxt_err = !pair_ok;
            if (pair_ok) begin
              nxt_prod = $signed(opa) * $signed(w_ff[wsel]);
            end
          end
          default: begin
            // Divide operands come straight from the addressed pair
            nxt_prod = {w_ff[base_sel], w_ff[wsel]};
          end
        endcase
      end
      default: nxt_state = dca_pkg::ST_IDLE;
    endcase
    if (apb_wr && paddr == `DCA_OFS_STAT) begin
      nxt_flags = pwdata[8:0];
    end
    if (apb_wr && paddr == `DCA_OFS_XADR) begin
      nxt_xdata = pwdata[15:0];
    end
    if (apb_wr && paddr == `DCA_OFS_YADR) begin
      nxt_ydata = pwdata[15:0];
    end
    if (apb_wr && paddr[11:6] == 6'h01 && state_ff == dca_pkg::ST_IDLE) begin
      nxt_w[paddr[5:2]] = pwdata[15:0];
    end
  end

  // Program memory write on the final sequencing cycle
  always_ff @(posedge pclk) begin
    if (state_ff == dca_pkg::ST_DONE && cmd_ff.op == dca_pkg::OP_PROG_HIGH_WRITE) begin
      prog_mem[paddr_of(w_ff[dst_sel])][23:16] <= w_ff[wsel][7:0];
    end else if (state_ff == dca_pkg::ST_DONE && cmd_ff.op == dca_pkg::OP_PROG_LOW_WRITE) begin
      prog_mem[paddr_of(w_ff[dst_sel])][15:0] <= w_ff[wsel];
    end else if (apb_wr && paddr == `DCA_OFS_PROG) begin
      prog_mem[paddr_of(w_ff[`DCA_W_DEFAULT])] <= pwdata[23:0];
    end
  end

  // ********************************
  // APB read path and write response
  // ********************************
  always_comb begin
    nxt_pready = psel && penable && !pready;
    nxt_pslverr = 1'b0;
    nxt_prdata = 32'h0000_0000;
    if (apb_rd) begin
      if (paddr == `DCA_OFS_CTRL) begin
        nxt_prdata = {30'h0000_0000, err_ff, state_ff != dca_pkg::ST_IDLE};
      end else if (paddr == `DCA_OFS_STAT) begin
        nxt_prdata = {23'h000000, flags_ff};
      end else if (paddr == `DCA_OFS_RES) begin
        nxt_prdata = prod_ff;
      end else if (paddr[11:6] == 6'h01) begin
        nxt_prdata = {16'h0000, w_ff[paddr[5:2]]};
      end else if (paddr == `DCA_OFS_ACCA) begin
        nxt_prdata = acc_ff[0][31:0];
      end else if (paddr == `DCA_OFS_ACCB) begin
        nxt_prdata = acc_ff[1][31:0];
      end else if (paddr == `DCA_OFS_XADR) begin
        nxt_prdata = {yadr_ff, xadr_ff};
      end else if (paddr == `DCA_OFS_PROG) begin
        nxt_prdata = {8'h00, pword};
      end else begin
        nxt_pslverr = 1'b1;
      end
    end else if (apb_wr) begin
      nxt_pslverr = !(paddr inside {`DCA_OFS_CTRL, `DCA_OFS_STAT, `DCA_OFS_XADR, `DCA_OFS_YADR,
                                    `DCA_OFS_PROG} || paddr[11:6] == 6'h01);
    end
  end

  // ********************************
  // Registers
  // ********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `DCA_NUM_W; i++) begin
        w_ff[i] <= 16'h0000;
      end
      acc_ff[0] <= 40'h0000000000;
      acc_ff[1] <= 40'h0000000000;
      flags_ff <= 9'h000;
      xdata_ff <= 16'h0000;
      ydata_ff <= 16'h0000;
      xadr_ff <= 16'h0000;
      yadr_ff <= 16'h0000;
      prod_ff <= 32'h0000_0000;
      err_ff <= 1'b0;
      res_ff <= 16'h0000;
      cmd_ff <= '0;
      state_ff <= dca_pkg::ST_IDLE;
      cnt_ff <= 2'h0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      busy <= 1'b0;
    end else begin
      for (int i = 0; i < `DCA_NUM_W; i++) begin
        w_ff[i] <= nxt_w[i];
      end
      acc_ff[0] <= nxt_acc[0];
      acc_ff[1] <= nxt_acc[1];
      flags_ff <= nxt_flags;
      xdata_ff <= nxt_xdata;
      ydata_ff <= nxt_ydata;
      xadr_ff <= nxt_xadr;
      yadr_ff <= nxt_yadr;
      prod_ff <= nxt_prod;
      err_ff <= nxt_err;
      res_ff <= nxt_res;
      cmd_ff <= nxt_cmd;
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      prdata <= nxt_prdata;
      pready <= nxt_pready;
      pslverr <= nxt_pslverr;
      busy <= nxt_state != dca_pkg::ST_IDLE;
    end
  end

  // ********************************
  // Checks
  // ********************************
  property p_rotate_flags;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == dca_pkg::ST_DONE && cmd_ff.op == dca_pkg::OP_ROTATE_RIGHT_NOCARRY)
      |=> (flags_ff[`DCA_FLAG_C] == $past(flags_ff[`DCA_FLAG_C]))
          && (flags_ff[`DCA_FLAG_OV] == $past(flags_ff[`DCA_FLAG_OV]));
  endproperty
  a_rotate_flags: assert property (p_rotate_flags) else $error("rotate touched C or OV");

  property p_prog_two_cycles;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == dca_pkg::ST_IDLE && nxt_state == dca_pkg::ST_PROG)
      |=> (state_ff == dca_pkg::ST_PROG) ##1 (state_ff == dca_pkg::ST_DONE);
  endproperty
  a_prog_two_cycles: assert property (p_prog_two_cycles) else $error("program access not two cycles");

  property p_sub_result;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == dca_pkg::ST_DONE && cmd_ff.op == dca_pkg::OP_SUB_WITH_BORROW)
      |=> res_ff == 16'($past(opa) - $past(opb) - {15'h0000, ~$past(flags_ff[`DCA_FLAG_C])});
  endproperty
  a_sub_result: assert property (p_sub_result) else $error("borrow subtract wrong");

  property p_low_read;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == dca_pkg::ST_DONE && cmd_ff.op == dca_pkg::OP_PROG_LOW_READ)
      |=> res_ff == $past(pword[15:0]);
  endproperty
  a_low_read: assert property (p_low_read) else $error("low program read wrong");

  property p_mul_pair;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == dca_pkg::ST_DONE && cmd_ff.op == dca_pkg::OP_DSP_MUL && base_sel == wsel) |=> err_ff;
  endproperty
  a_mul_pair: assert property (p_mul_pair) else $error("illegal multiply pair accepted");

  property p_zero_fill;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == dca_pkg::ST_DONE && cmd_ff.op == dca_pkg::OP_ZERO_FILL) |=> res_ff[15:8] == 8'h00;
  endproperty
  a_zero_fill: assert property (p_zero_fill) else $error("zero extend left high bits");

  property p_shift_flags;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == dca_pkg::ST_DONE && cmd_ff.op == dca_pkg::OP_SHIFT_LEFT)
      |=> $stable(flags_ff[`DCA_FLAG_C]) && $stable(flags_ff[`DCA_FLAG_DC]);
  endproperty
  a_shift_flags: assert property (p_shift_flags) else $error("left shift touched C or DC");

  property p_idle_flags;
    @(posedge pclk) disable iff (!presetn)
    (state_ff != dca_pkg::ST_DONE && !(apb_wr && paddr == `DCA_OFS_STAT)) |=> $stable(flags_ff);
  endproperty
  a_idle_flags: assert property (p_idle_flags) else $error("flags changed with no operation");
endmodule

// ===== bench/dca_apb_master.sv
`timescale 1ns/1ps
// ********************************
// Decoder side bus master model
// ********************************
module dca_apb_master (
  // Clock
  input wire logic pclk,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  // Held until pready seen high at an edge; released lines show inverted data
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ===== bench/dsp_core_alu_subset_tb.sv
`timescale 1ns/1ps
`include "dca_regs.svh"
module dsp_core_alu_subset_tb;
  // ********************************
  // Signals
  // ********************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int err_count = 0;
  int checks_done = 0;
  int seed = 32'habe4eb5b;
  int bcnt = 0;
  int blast = 0;
  logic [15:0] mw [16];
  always #4 pclk = ~pclk;
  // Busy length of the last command
  always @(posedge pclk) begin
    if (busy === 1'b1) bcnt <= bcnt + 1;
    else if (bcnt != 0) begin
      blast <= bcnt;
      bcnt <= 0;
    end
  end
  dca_core #(.PROG_DEPTH(64), .PROG_AW(6)) dca_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy));
  dca_apb_master dca_apb_master_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ********************************
  // Tasks
  // ********************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    dca_apb_master_inst.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] r, output logic e);
    dca_apb_master_inst.xfer(1'b0, a, 32'h00000000, r, e);
  endtask
  task automatic default_work_reg(input logic [3:0] n, input logic [15:0] v);
    wr(`DCA_OFS_WBASE + {6'h00, n, 2'h0}, {16'h0000, v});
    mw[n] = v;
  endtask
  // Polls busy instead of assuming a latency
  task automatic run(input dca_pkg::dca_op_e op, input logic [3:0] s, input logic [3:0] b,
                     input logic [3:0] d, input logic ul = 1'b0, input logic [5:0] lit = 6'h00,
                     input logic sb = 1'b0, input logic [2:0] xm = 3'h0);
    dca_pkg::dca_cmd_s c;
    logic [31:0] r;
    logic e;
    int n;
    c = '0;
    c.op = op;
    c.src = s;
    c.base = b;
    c.dst = d;
    c.use_lit = ul;
    c.lit = lit;
    c.src_byte = sb;
    c.xmode = xm;
    wr(`DCA_OFS_CTRL, {1'b0, c});
    n = 0;
    do begin
      rd(`DCA_OFS_CTRL, r, e);
      n++;
    end while (r[0] !== 1'b0 && n < 20);
  endtask
  // Random operands and flags through one operation, model against design
  task automatic op_test(input dca_pkg::dca_op_e op);
    logic [15:0] a, b, x, y, res;
    logic [8:0] f, fe, m;
    logic [16:0] t;
    logic [4:0] h;
    logic [31:0] r;
    logic e, ul, sb;
    logic [3:0] s, bs, d, dd;
    logic [5:0] lit;
    s = 4'($random(seed));
    bs = s ^ (4'($random(seed)) | 4'h1);
    d = 4'($random(seed));
    ul = (op > dca_pkg::OP_SET_ONES) ? 1'($random(seed)) : 1'b0;
    sb = (op == dca_pkg::OP_ROTATE_RIGHT_NOCARRY) ? 1'($random(seed)) : 1'b0;
    lit = {1'b0, 5'($random(seed))};
    default_work_reg(s, (op == dca_pkg::OP_SHIFT_LEFT) ? 16'($random(seed)) & 16'h001F : 16'($random(seed)));
    default_work_reg(bs, 16'($random(seed)));
    f = 9'($random(seed));
    wr(`DCA_OFS_STAT, {23'h000000, f});
    a = mw[bs];
    b = ul ? {11'h000, lit[4:0]} : mw[s];
    fe = f;
    m = 9'h1FF;
    case (op)
      dca_pkg::OP_SET_ONES: res = 16'hFFFF;
      dca_pkg::OP_ROTATE_RIGHT_NOCARRY: res = {mw[s][0], mw[s][15:1]};
      dca_pkg::OP_SIGN_EXTEND: begin
        res = {{8{mw[s][7]}}, mw[s][7:0]};
        m[`DCA_FLAG_C] = 1'b0;
      end
      dca_pkg::OP_ZERO_FILL: begin
        res = {8'h00, mw[s][7:0]};
        m[`DCA_FLAG_C] = 1'b0;
      end
      dca_pkg::OP_SHIFT_LEFT: res = (b > 16'h000F) ? 16'h0000 : a << b[3:0];
      default: begin
        x = (op == dca_pkg::OP_SUB_WITH_BORROW) ? a : b;
        y = (op == dca_pkg::OP_SUB_WITH_BORROW) ? b : a;
        t = {1'b0, x} - {1'b0, y} - {16'h0000, ~f[`DCA_FLAG_C]};
        h = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, ~f[`DCA_FLAG_C]};
        res = t[15:0];
        fe[`DCA_FLAG_C] = ~t[16];
        fe[`DCA_FLAG_DC] = ~h[4];
        fe[`DCA_FLAG_OV] = (x[15] != y[15]) && (res[15] != x[15]);
      end
    endcase
    if (op != dca_pkg::OP_SET_ONES) begin
      fe[`DCA_FLAG_N] = res[15];
      fe[`DCA_FLAG_Z] = (res == 16'h0000);
    end
    dd = sb ? 4'h0 : d;
    run(op, s, bs, d, ul, lit, sb);
    mw[dd] = res;
    rd(`DCA_OFS_WBASE + {6'h00, dd, 2'h0}, r, e);
    check(r, {16'h0000, res});
    rd(`DCA_OFS_STAT, r, e);
    check(r & {23'h000000, m}, {23'h000000, fe & m});
  endtask
  // ********************************
  // Tests
  // ********************************
  initial begin
    repeat (60000) @(posedge pclk);
    err_count++;
    finish_test();
  end
  initial begin
    logic [31:0] r, w;
    logic [8:0] f;
    logic e;
    int sgl;
    dca_pkg::dca_op_e ops [7];
    ops = '{dca_pkg::OP_SET_ONES, dca_pkg::OP_SIGN_EXTEND, dca_pkg::OP_ZERO_FILL,
            dca_pkg::OP_SHIFT_LEFT, dca_pkg::OP_SUB_WITH_BORROW, dca_pkg::OP_REVERSE_SUB_WITH_BORROW,
            dca_pkg::OP_ROTATE_RIGHT_NOCARRY};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 16; i++) default_work_reg(4'(i), 16'($random(seed)));
    for (int i = 0; i < 16; i++) begin
      rd(`DCA_OFS_WBASE + 12'(i * 4), r, e);
      check(r, {16'h0000, mw[i]});
    end
    rd(12'hFFC, r, e);
    check({31'h00000000, e}, 32'h00000001);
    $display("register file test done");
    for (int k = 0; k < 8; k++) begin
      foreach (ops[j]) op_test(ops[j]);
    end
    $display("operation test done");
    // Program memory: pointer kept in W0 so source and destination agree
    check(blast, 32'h00000001);
    default_work_reg(4'h0, {9'h000, 6'($random(seed)), 1'b0});
    w = {8'h00, 24'($random(seed))};
    wr(`DCA_OFS_PROG, w);
    wr(`DCA_OFS_STAT, 32'h000000AA);
    run(dca_pkg::OP_PROG_HIGH_WRITE, 4'h0, 4'h0, 4'h0);
    check(blast, 32'h00000002);
    w[23:16] = mw[0][7:0];
    rd(`DCA_OFS_PROG, r, e);
    check(r, w);
    run(dca_pkg::OP_PROG_LOW_WRITE, 4'h0, 4'h0, 4'h0);
    w[15:0] = mw[0];
    rd(`DCA_OFS_PROG, r, e);
    check(r, w);
    run(dca_pkg::OP_PROG_HIGH_READ, 4'h0, 4'h0, 4'h5);
    check(blast, 32'h00000002);
    rd(`DCA_OFS_WBASE + 12'h014, r, e);
    check({24'h000000, r[7:0]}, {24'h000000, w[23:16]});
    run(dca_pkg::OP_PROG_LOW_READ, 4'h0, 4'h0, 4'h6);
    rd(`DCA_OFS_WBASE + 12'h018, r, e);
    check(r, {16'h0000, w[15:0]});
    rd(`DCA_OFS_STAT, r, e);
    check(r, 32'h000000AA);
    $display("program memory test done");
    // Multiply pairs, square, divide pair and X prefetch
    default_work_reg(4'h4, 16'($random(seed)));
    default_work_reg(4'h6, 16'($random(seed)));
    run(dca_pkg::OP_DSP_MUL, 4'h6, 4'h4, 4'h0);
    rd(`DCA_OFS_RES, r, e);
    sgl = $signed(mw[4]) * $signed(mw[6]);
    check(r, sgl);
    run(dca_pkg::OP_DSP_MUL, 4'h5, 4'h5, 4'h0);
    rd(`DCA_OFS_CTRL, r, e);
    check(r, 32'h00000002);
    run(dca_pkg::OP_SQUARE, 4'h0, 4'h0, 4'h6);
    rd(`DCA_OFS_RES, r, e);
    sgl = $signed(mw[6]) * $signed(mw[6]);
    check(r, sgl);
    run(dca_pkg::OP_NOP, 4'h6, 4'h4, 4'h0);
    rd(`DCA_OFS_RES, r, e);
    check(r, {mw[4], mw[6]});
    default_work_reg(4'h8, 16'h0100);
    wr(`DCA_OFS_XADR, w);
    run(dca_pkg::OP_PREFETCH, 4'h0, 4'h0, 4'h1, 1'b0, 6'h00, 1'b0, 3'h1);
    rd(`DCA_OFS_WBASE + 12'h014, r, e);
    check(r, {16'h0000, w[15:0]});
    rd(`DCA_OFS_WBASE + 12'h020, r, e);
    check(r, 32'h00000102);
    // Accumulator has no bus write path: zero shifts to zero, core flags kept
    f = 9'($random(seed)) & 9'h01F;
    wr(`DCA_OFS_ACCA, 32'h00000010);
    wr(`DCA_OFS_STAT, {23'h000000, f});
    run(dca_pkg::OP_ACCUM_ARITH_SHIFT, 4'h0, 4'h0, 4'h0, 1'b1, 6'h01, 1'b0);
    rd(`DCA_OFS_STAT, r, e);
    check(r & 32'h000000BF, {23'h000000, f});
    rd(`DCA_OFS_ACCA, r, e);
    check(r, 32'h00000000);
    $display("multiply and accumulator test done");
    finish_test();
  end
endmodule
